/* ccr_host.sv */
`timescale 1ns/1ns
// ====================
// host driving the serial port
module ccr_host (
  input wire logic mclk,
  output logic cfg_clk,
  output logic cfg_data,
  output logic cfg_latch
);
  initial begin
    cfg_clk = 1'b0;
    cfg_data = 1'b0;
    cfg_latch = 1'b0;
  end
  task automatic send(input logic [3:0] addr, input logic [31:0] val, input int hold);
    logic [31:0] word;
    word = {val[31:4], addr};
    // reserved registers keep their power-on contents, so never sent
    if (addr inside {4'h5, 4'h6, 4'h8, 4'h9}) return;
    for (int i = 31; i >= 0; i--) begin
      @(negedge mclk);
      cfg_data = word[i];
      repeat (hold) @(negedge mclk);
      cfg_clk = 1'b1;
      repeat (hold) @(negedge mclk);
      cfg_clk = 1'b0;
    end
    repeat (hold) @(negedge mclk);
    // released data line shows the inverse so a stale bit cannot pass
    cfg_data = ~word[0];
    cfg_latch = 1'b1;
    repeat (hold) @(negedge mclk);
    cfg_latch = 1'b0;
    repeat (hold) @(negedge mclk);
  endtask
endmodule

/* ccr_pkg.sv */
package ccr_pkg;
  // ==========================================
  // serial word layout
  localparam int CCR_WORD_W = 32;
  localparam int CCR_ADDR_W = 4;
  localparam int CCR_CHANNELS = 5;
  localparam int CCR_PIN_SYNC = 3;
  localparam logic [3:0] CCR_A_CH_LAST = 4'h4;
  localparam logic [3:0] CCR_A_SOFT_RST = 4'h7;
  localparam logic [3:0] CCR_A_TUNE = 4'hA;
  localparam logic [3:0] CCR_A_REF_IN = 4'hB;
  localparam logic [3:0] CCR_A_CLEANER = 4'hC;
  localparam logic [3:0] CCR_A_GLOBAL = 4'hD;
  localparam logic [3:0] CCR_A_SYNTH_REF = 4'hE;
  localparam logic [3:0] CCR_A_SYNTH_FB = 4'hF;
  // ==========================================
  // field positions and widths
  localparam int CCR_SOFT_RST_BIT = 17;
  localparam int CCR_SWING_BIT = 23;
  localparam int CCR_B_STATE_LSB = 21;
  localparam int CCR_A_STATE_LSB = 19;
  localparam int CCR_STATE_W = 2;
  localparam int CCR_ON_BIT = 16;
  localparam int CCR_TUNE_WAIT_BIT = 29;
  localparam int CCR_BUF1_BIT = 11;
  localparam int CCR_BUF0_BIT = 10;
  localparam int CCR_LOS_MIN_LSB = 8;
  localparam int CCR_SIGNAL_LOSS_OUTPUT_TYPE_LSB = 6;
  localparam int CCR_SEL_LSB = 4;
  localparam int CCR_FIELD2_W = 2;
  localparam int CCR_POL_BIT = 31;
  localparam int CCR_CPG_LSB = 28;
  localparam int CCR_CPG_W = 3;
  localparam int CCR_CLR_R_LSB = 16;
  localparam int CCR_CLR_N_LSB = 4;
  localparam int CCR_DIV12_W = 12;
  localparam int CCR_XTAL_BIT = 21;
  localparam int CCR_OSCBUF_BIT = 20;
  localparam int CCR_GLOBAL_BIT = 18;
  localparam int CCR_PDN_BIT = 17;
  localparam int CCR_DBL_BIT = 16;
  localparam int CCR_SFLOAT_BIT = 15;
  localparam int CCR_CFLOAT_BIT = 14;
  localparam int CCR_FREQ_LSB = 21;
  localparam int CCR_FREQ_W = 8;
  localparam int CCR_LDSEL_LSB = 16;
  localparam int CCR_LDSEL_W = 5;
  localparam int CCR_SR_LSB = 4;
  localparam int CCR_SPG_LSB = 26;
  localparam int CCR_ODIV_LSB = 22;
  localparam int CCR_ODIV_W = 4;
  localparam int CCR_SN_LSB = 4;
  localparam int CCR_SN_W = 18;
  // ==========================================
  // power-on field values
  localparam logic [31:0] CCR_ONE = 32'h1;
  localparam int CCR_DEF_CH_ON = 2;
  localparam logic [31:0] CCR_CH_DEF = 32'h0;
  localparam logic [31:0] CCR_CH_CMOS_DEF = CCR_ONE << CCR_A_STATE_LSB;
  localparam logic [31:0] CCR_RES_DEF = 32'h0;
  localparam logic [31:0] CCR_TUNE_DEF = CCR_ONE << CCR_TUNE_WAIT_BIT;
  localparam logic [31:0] CCR_REF_IN_DEF = (CCR_ONE << CCR_BUF1_BIT)
    | (CCR_ONE << CCR_BUF0_BIT) | (CCR_ONE << CCR_LOS_MIN_LSB)
    | (32'h3 << CCR_SIGNAL_LOSS_OUTPUT_TYPE_LSB);
  localparam logic [31:0] CCR_CLEANER_DEF = (CCR_ONE << CCR_POL_BIT)
    | (32'h6 << CCR_CPG_LSB) | (CCR_ONE << CCR_CLR_R_LSB) | (CCR_ONE << CCR_CLR_N_LSB);
  localparam logic [31:0] CCR_GLOBAL_DEF = CCR_ONE << CCR_GLOBAL_BIT;
  localparam logic [31:0] CCR_SYNTH_REF_DEF = (32'hC8 << CCR_FREQ_LSB)
    | (32'h1F << CCR_LDSEL_LSB) | (CCR_ONE << CCR_SR_LSB);
  localparam logic [31:0] CCR_SYNTH_FB_DEF = (32'h2 << CCR_SPG_LSB)
    | (32'h2 << CCR_ODIV_LSB) | (CCR_ONE << CCR_SN_LSB);
  typedef enum logic [1:0] {TUNE_IDLE, TUNE_WAIT, TUNE_RUN} ccr_tune_t;
endpackage

/* ccr_regs.sv */
`timescale 1ns/1ns
module ccr_regs import ccr_pkg::*; #(
  parameter int CHANNELS = CCR_CHANNELS
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic cfg_clk,
  input wire logic cfg_data,
  input wire logic cfg_latch,
  input wire logic cleaner_locked,
  // ==========================================
  // per-channel fields
  output logic [CHANNELS-1:0] channel_swing_level_select,
  output logic [2*CHANNELS-1:0] channel_second_output_state,
  output logic [2*CHANNELS-1:0] channel_first_output_state,
  output logic [CHANNELS-1:0] channel_output_on,
  output logic [CHANNELS-1:0] channel_drive_on,
  // ==========================================
  // tuning sequencer
  output logic tune_wait_for_ref_lock,
  output logic tune_start,
  output logic tune_waiting,
  // ==========================================
  // reference inputs
  output logic ref_input1_buffer_type,
  output logic ref_input0_buffer_type,
  output logic [1:0] signal_loss_min_freq,
  output logic [1:0] signal_loss_output_type,
  output logic [1:0] reference_source_select,
  output logic select_conflict,
  // ==========================================
  // first loop
  output logic cleaner_pump_polarity,
  output logic [2:0] cleaner_pump_gain,
  output logic [11:0] cleaner_reference_divider,
  output logic [11:0] cleaner_feedback_divider,
  // ==========================================
  // global and power
  output logic synth_reference_doubler_on,
  output logic crystal_support_on,
  output logic osc_buffer_on,
  output logic all_outputs_on,
  output logic power_down,
  output logic synth_pump_float,
  output logic cleaner_pump_float,
  // ==========================================
  // second loop
  output logic [7:0] osc_input_frequency_mhz,
  output logic [4:0] lock_detect_select,
  output logic [11:0] synth_reference_divider,
  output logic [1:0] synth_pump_gain,
  output logic [3:0] osc_output_divider,
  output logic [17:0] synth_feedback_divider
);
  // ==========================================
  // pin synchronisers and serial receiver
  // three stages filter pin glitches at the cost of four cycles of latency
  logic [3:0] pin_level;
  logic wr_stb;
  logic [CCR_WORD_W-1:0] wr_word;

  ccr_sync #(.N(4)) u_sync (
    .mclk(mclk),
    .srst(srst),
    .pin({cleaner_locked, cfg_latch, cfg_data, cfg_clk}),
    .level(pin_level)
  );

  ccr_shift u_shift (
    .mclk(mclk),
    .srst(srst),
    .sclk_level(pin_level[0]),
    .sdata_level(pin_level[1]),
    .latch_level(pin_level[2]),
    .wr_stb(wr_stb),
    .wr_word(wr_word)
  );

  // ==========================================
  // write decode
  wire [CCR_ADDR_W-1:0] wr_addr = wr_word[CCR_ADDR_W-1:0];
  wire [CCR_WORD_W-1:0] wr_value = {wr_word[CCR_WORD_W-1:CCR_ADDR_W], 4'h0};
  wire soft_reset = wr_stb && (wr_addr == CCR_A_SOFT_RST) && wr_word[CCR_SOFT_RST_BIT];
  wire load_defaults = srst | soft_reset;
  wire wr_tune = wr_stb && (wr_addr == CCR_A_TUNE);
  wire wr_ref_in = wr_stb && (wr_addr == CCR_A_REF_IN);
  wire wr_cleaner = wr_stb && (wr_addr == CCR_A_CLEANER);
  wire wr_global = wr_stb && (wr_addr == CCR_A_GLOBAL);
  wire wr_synth_ref = wr_stb && (wr_addr == CCR_A_SYNTH_REF);
  wire wr_synth_fb = wr_stb && (wr_addr == CCR_A_SYNTH_FB);
  // reserved addresses 5, 6, 8, 9 are never decoded, so they keep their contents
  // address 7 is a strobe only; nothing written there is stored
  // bits 3:0 carry the address, so every register stores them as zero

  // ==========================================
  // channel registers
  logic [CCR_WORD_W-1:0] chan_ctrl [0:CHANNELS-1];

  genvar c;
  generate
    for (c = 0; c < CHANNELS; c++) begin : g_chan
      // channels 0 and 4 reset both cmos state fields to zero
      // a channel write replaces the whole word, not single fields
      localparam logic [CCR_WORD_W-1:0] CMOS_BITS =
        (c >= 1 && c <= 3) ? CCR_CH_CMOS_DEF : CCR_CH_DEF;
      localparam logic [CCR_WORD_W-1:0] ON_BITS =
        (c == CCR_DEF_CH_ON) ? (CCR_ONE << CCR_ON_BIT) : CCR_CH_DEF;
      wire wr_this = wr_stb && (wr_addr == 4'(c));

      always_ff @(posedge mclk) begin
        if (load_defaults) begin
          chan_ctrl[c] <= CMOS_BITS | ON_BITS;
        end else if (wr_this) begin
          chan_ctrl[c] <= wr_value;
        end
      end

      assign channel_swing_level_select[c] = chan_ctrl[c][CCR_SWING_BIT];
      assign channel_second_output_state[2*c +: 2] =
        chan_ctrl[c][CCR_B_STATE_LSB +: CCR_STATE_W];
      assign channel_first_output_state[2*c +: 2] =
        chan_ctrl[c][CCR_A_STATE_LSB +: CCR_STATE_W];
      assign channel_output_on[c] = chan_ctrl[c][CCR_ON_BIT];
    end
  endgenerate

  // ==========================================
  // loop, input and global registers
  logic [CCR_WORD_W-1:0] tune_ctrl;
  logic [CCR_WORD_W-1:0] ref_in_ctrl;
  logic [CCR_WORD_W-1:0] cleaner_ctrl;
  logic [CCR_WORD_W-1:0] global_ctrl;
  logic [CCR_WORD_W-1:0] synth_ref_ctrl;
  logic [CCR_WORD_W-1:0] synth_fb_ctrl;

  // ==========================================
  // tuning wait register
  always_ff @(posedge mclk) begin
    if (load_defaults) begin
      tune_ctrl <= CCR_TUNE_DEF;
    end else if (wr_tune) begin
      tune_ctrl <= wr_value;
    end
  end

  // ==========================================
  // reference input register
  always_ff @(posedge mclk) begin
    if (load_defaults) begin
      ref_in_ctrl <= CCR_REF_IN_DEF;
    end else if (wr_ref_in) begin
      ref_in_ctrl <= wr_value;
    end
  end

  // ==========================================
  // first loop register
  always_ff @(posedge mclk) begin
    if (load_defaults) begin
      cleaner_ctrl <= CCR_CLEANER_DEF;
    end else if (wr_cleaner) begin
      cleaner_ctrl <= wr_value;
    end
  end

  // ==========================================
  // global power register
  always_ff @(posedge mclk) begin
    if (load_defaults) begin
      global_ctrl <= CCR_GLOBAL_DEF;
    end else if (wr_global) begin
      global_ctrl <= wr_value;
    end
  end

  // ==========================================
  // second loop reference register
  always_ff @(posedge mclk) begin
    if (load_defaults) begin
      synth_ref_ctrl <= CCR_SYNTH_REF_DEF;
    end else if (wr_synth_ref) begin
      synth_ref_ctrl <= wr_value;
    end
  end

  // ==========================================
  // second loop feedback register
  always_ff @(posedge mclk) begin
    if (load_defaults) begin
      synth_fb_ctrl <= CCR_SYNTH_FB_DEF;
    end else if (wr_synth_fb) begin
      synth_fb_ctrl <= wr_value;
    end
  end

  // ==========================================
  // field outputs
  // every field is a plain slice of its register flop
  assign tune_wait_for_ref_lock =
    tune_ctrl[CCR_TUNE_WAIT_BIT];

  assign ref_input1_buffer_type =
    ref_in_ctrl[CCR_BUF1_BIT];
  assign ref_input0_buffer_type =
    ref_in_ctrl[CCR_BUF0_BIT];
  assign signal_loss_min_freq =
    ref_in_ctrl[CCR_LOS_MIN_LSB +: CCR_FIELD2_W];
  assign signal_loss_output_type =
    ref_in_ctrl[CCR_SIGNAL_LOSS_OUTPUT_TYPE_LSB +: CCR_FIELD2_W];
  assign reference_source_select =
    ref_in_ctrl[CCR_SEL_LSB +: CCR_FIELD2_W];

  assign cleaner_pump_polarity =
    cleaner_ctrl[CCR_POL_BIT];
  assign cleaner_pump_gain =
    cleaner_ctrl[CCR_CPG_LSB +: CCR_CPG_W];
  assign cleaner_reference_divider =
    cleaner_ctrl[CCR_CLR_R_LSB +: CCR_DIV12_W];
  assign cleaner_feedback_divider =
    cleaner_ctrl[CCR_CLR_N_LSB +: CCR_DIV12_W];

  assign synth_reference_doubler_on =
    global_ctrl[CCR_DBL_BIT];
  assign crystal_support_on =
    global_ctrl[CCR_XTAL_BIT];
  assign osc_buffer_on =
    global_ctrl[CCR_OSCBUF_BIT];
  assign all_outputs_on =
    global_ctrl[CCR_GLOBAL_BIT];
  assign power_down =
    global_ctrl[CCR_PDN_BIT];
  assign synth_pump_float =
    global_ctrl[CCR_SFLOAT_BIT];
  assign cleaner_pump_float =
    global_ctrl[CCR_CFLOAT_BIT];

  assign osc_input_frequency_mhz =
    synth_ref_ctrl[CCR_FREQ_LSB +: CCR_FREQ_W];
  assign lock_detect_select =
    synth_ref_ctrl[CCR_LDSEL_LSB +: CCR_LDSEL_W];
  assign synth_reference_divider =
    synth_ref_ctrl[CCR_SR_LSB +: CCR_DIV12_W];

  assign synth_pump_gain =
    synth_fb_ctrl[CCR_SPG_LSB +: CCR_FIELD2_W];
  assign osc_output_divider =
    synth_fb_ctrl[CCR_ODIV_LSB +: CCR_ODIV_W];
  assign synth_feedback_divider =
    synth_fb_ctrl[CCR_SN_LSB +: CCR_SN_W];

  // ==========================================
  // effective channel drive
  // registered so that a write lands on all gates in the same cycle
  wire [CHANNELS-1:0] next_drive_on =
    channel_output_on & {CHANNELS{all_outputs_on & ~power_down}};
  // power down overrides every channel bit, the channel 2 default too

  always_ff @(posedge mclk) begin
    if (srst) begin
      channel_drive_on <= '0;
    end else begin
      channel_drive_on <= next_drive_on;
    end
  end

  // ==========================================
  // host misuse flag: loss type must be 0 with manual select 0 or 1
  // only reported; the written value is kept as the host gave it
  // reset defaults already raise it: select 0 with loss type 3
  wire next_conflict = (reference_source_select < 2'h2)
    && (signal_loss_output_type != 2'h0);

  always_ff @(posedge mclk) begin
    if (srst) begin
      select_conflict <= 1'b0;
    end else begin
      select_conflict <= next_conflict;
    end
  end

  // ==========================================
  // oscillator tuning sequencer
  // a run is requested at reset and on each synth feedback write
  // with the wait bit set, a lock that never comes leaves the sequencer waiting; it has no timeout
  ccr_tune_t tune_state;
  ccr_tune_t next_tune_state;
  wire locked = pin_level[3];
  wire tune_go = ~tune_wait_for_ref_lock | locked;

  always_comb begin
    next_tune_state = tune_state;
    unique case (tune_state)
      TUNE_IDLE: begin
        if (wr_synth_fb) next_tune_state = TUNE_WAIT;
      end
      TUNE_WAIT: begin
        if (tune_go) next_tune_state = TUNE_RUN;
      end
      TUNE_RUN: begin
        next_tune_state = wr_synth_fb ? TUNE_WAIT : TUNE_IDLE;
      end
      default: begin
        next_tune_state = TUNE_WAIT;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (load_defaults) begin
      tune_state <= TUNE_WAIT;
      tune_start <= 1'b0;
      tune_waiting <= 1'b0;
    end else begin
      tune_state <= next_tune_state;
      tune_start <= (next_tune_state == TUNE_RUN);
      tune_waiting <= (next_tune_state == TUNE_WAIT);
    end
  end
endmodule

/* ccr_regs_asserts.sv */
`timescale 1ns/1ns
// ====================
// port checker for the register bank
module ccr_regs_chk import ccr_pkg::*; #(
  parameter int CHANNELS = CCR_CHANNELS
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic cfg_latch,
  input wire logic cleaner_locked,
  input wire logic [CHANNELS-1:0] channel_output_on,
  input wire logic [CHANNELS-1:0] channel_drive_on,
  input wire logic all_outputs_on,
  input wire logic power_down,
  input wire logic tune_wait_for_ref_lock,
  input wire logic tune_start,
  input wire logic tune_waiting,
  input wire logic [1:0] reference_source_select,
  input wire logic [1:0] signal_loss_output_type,
  input wire logic select_conflict,
  input wire logic [2:0] cleaner_pump_gain,
  input wire logic [17:0] synth_feedback_divider
);
  logic latch_q;
  logic [7:0] lat_age;
  logic [CHANNELS-1:0] gate;
  assign gate = channel_output_on & {CHANNELS{all_outputs_on & ~power_down}};
  // age of the last latch pin rise; fields may only move shortly after one
  always_ff @(posedge mclk) begin
    latch_q <= cfg_latch;
    if (srst) begin
      lat_age <= 8'hFF;
    end else if (cfg_latch && !latch_q) begin
      lat_age <= 8'h00;
    end else if (lat_age != 8'hFF) begin
      lat_age <= lat_age + 8'h01;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  sequence lock_low_s;
    (tune_wait_for_ref_lock && !cleaner_locked) [*8];
  endsequence
  sequence clash_s;
    (reference_source_select < 2'h2 && signal_loss_output_type != 2'h0) [*2];
  endsequence
  sequence calm_s;
    (reference_source_select > 2'h1 || signal_loss_output_type == 2'h0) [*2];
  endsequence
  AST_DRIVE: assert property (
    !$past(srst) |-> channel_drive_on == $past(gate)) else $error("drive gating wrong");
  AST_GLOBAL_OFF: assert property (
    (!all_outputs_on) [*2] |-> channel_drive_on == '0) else $error("outputs on while off");
  AST_TUNE_PULSE: assert property (
    tune_start |=> !tune_start) else $error("tune start too long");
  AST_TUNE_EXCL: assert property (
    !(tune_start && tune_waiting)) else $error("start while waiting");
  AST_WAIT_LOCK: assert property (
    lock_low_s |-> !tune_start) else $error("tuning ran without lock");
  AST_WAIT_SKIP: assert property (
    tune_waiting && !tune_wait_for_ref_lock |-> ##[1:3] !tune_waiting)
    else $error("wait not skipped");
  AST_CLASH_SET: assert property (
    clash_s |-> select_conflict) else $error("conflict not flagged");
  AST_CLASH_CLR: assert property (
    calm_s |-> !select_conflict) else $error("false conflict");
  AST_WRITE_ONLY: assert property (
    $changed({cleaner_pump_gain, synth_feedback_divider, channel_output_on})
    |-> lat_age <= 8'h0E) else $error("field moved without a write");
endmodule

bind ccr_regs ccr_regs_chk #(.CHANNELS(CHANNELS)) u_chk (
  .mclk(mclk), .srst(srst), .cfg_latch(cfg_latch), .cleaner_locked(cleaner_locked),
  .channel_output_on(channel_output_on), .channel_drive_on(channel_drive_on),
  .all_outputs_on(all_outputs_on), .power_down(power_down),
  .tune_wait_for_ref_lock(tune_wait_for_ref_lock), .tune_start(tune_start),
  .tune_waiting(tune_waiting), .reference_source_select(reference_source_select),
  .signal_loss_output_type(signal_loss_output_type), .select_conflict(select_conflict),
  .cleaner_pump_gain(cleaner_pump_gain), .synth_feedback_divider(synth_feedback_divider));

/* ccr_regs_bench.sv */
`timescale 1ns/1ns
`define CHK(a, b) begin \
  compares++; \
  if ((a) !== (b)) begin \
    bad_count++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, (a), (b)); \
  end \
end
module ccr_regs_bench;
  logic mclk, srst, cfg_clk, cfg_data, cfg_latch, cleaner_locked;
  logic [4:0] channel_swing_level_select, channel_output_on, channel_drive_on;
  logic [9:0] channel_second_output_state, channel_first_output_state;
  logic tune_wait_for_ref_lock, tune_start, tune_waiting, ref_input1_buffer_type;
  logic ref_input0_buffer_type, select_conflict, cleaner_pump_polarity, osc_buffer_on;
  logic [1:0] signal_loss_min_freq, signal_loss_output_type, reference_source_select;
  logic [2:0] cleaner_pump_gain;
  logic [11:0] cleaner_reference_divider, cleaner_feedback_divider, synth_reference_divider;
  logic synth_reference_doubler_on, crystal_support_on, all_outputs_on;
  logic power_down, synth_pump_float, cleaner_pump_float, seen;
  logic [7:0] osc_input_frequency_mhz;
  logic [4:0] lock_detect_select;
  logic [1:0] synth_pump_gain;
  logic [3:0] osc_output_divider;
  logic [17:0] synth_feedback_divider;
  logic [31:0] ex [16];
  logic [31:0] chv [5];
  int bad_count = 0;
  int compares = 0;
  ccr_regs DUT (.*);
  ccr_host host (.mclk(mclk), .cfg_clk(cfg_clk), .cfg_data(cfg_data), .cfg_latch(cfg_latch));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // ====================
  // shared tasks
  task automatic print_verdict();
    $display("mismatches %0d compares %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic load_def();
    ex[0] = 32'h0000_0000;
    ex[1] = 32'h0008_0000;
    ex[2] = 32'h0009_0000;
    ex[3] = 32'h0008_0000;
    ex[4] = 32'h0000_0000;
    ex[10] = 32'h2000_0000;
    ex[11] = 32'h0000_0DC0;
    ex[12] = 32'hE001_0010;
    ex[13] = 32'h0004_0000;
    ex[14] = 32'h191F_0010;
    ex[15] = 32'h0880_0010;
  endtask
  task automatic check_all();
    for (int n = 0; n < 5; n++) begin
      `CHK(channel_swing_level_select[n], ex[n][23])
      `CHK(channel_second_output_state[2*n+:2], ex[n][22:21])
      `CHK(channel_first_output_state[2*n+:2], ex[n][20:19])
      `CHK(channel_output_on[n], ex[n][16])
      `CHK(channel_drive_on[n], ex[n][16] & ex[13][18] & ~ex[13][17])
    end
    `CHK(tune_wait_for_ref_lock, ex[10][29])
    `CHK({ref_input1_buffer_type, ref_input0_buffer_type}, ex[11][11:10])
    `CHK({signal_loss_min_freq, signal_loss_output_type}, ex[11][9:6])
    `CHK(reference_source_select, ex[11][5:4])
    `CHK({cleaner_pump_polarity, cleaner_pump_gain}, ex[12][31:28])
    `CHK({cleaner_reference_divider, cleaner_feedback_divider}, ex[12][27:4])
    `CHK({crystal_support_on, osc_buffer_on}, ex[13][21:20])
    `CHK({all_outputs_on, power_down, synth_reference_doubler_on}, ex[13][18:16])
    `CHK({synth_pump_float, cleaner_pump_float}, ex[13][15:14])
    `CHK(osc_input_frequency_mhz, ex[14][28:21])
    `CHK(lock_detect_select, ex[14][20:16])
    `CHK(synth_reference_divider, ex[14][15:4])
    `CHK(synth_feedback_divider, ex[15][21:4])
    `CHK({synth_pump_gain, osc_output_divider}, ex[15][27:22])
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v, input int hold);
    host.send(a, v, hold);
    ex[a] = {v[31:4], 4'h0};
    repeat (12) @(negedge mclk);
    check_all();
  endtask
  // ====================
  // main sequence
  initial begin
    srst = 1'b1;
    cleaner_locked = 1'b0;
    repeat (16) @(negedge mclk);
    srst = 1'b0;
    repeat (4) @(negedge mclk);
    load_def();
    check_all();
    `CHK({tune_waiting, tune_start}, 2'h2)
    `CHK(select_conflict, 1'b1)
    chv = '{32'h00E1_0000, 32'h0068_0000, 32'h0030_0000, 32'h00D8_0000, 32'h0081_0000};
    for (int n = 0; n < 5; n++) begin
      wr(n[3:0], chv[n], 4);
    end
    wr(4'hD, 32'h0033_C000, 4);
    wr(4'hD, 32'h0005_0000, 4);
    // loss output type kept 0 while selecting input 1
    wr(4'hB, 32'h0000_0910, 4);
    `CHK(select_conflict, 1'b0)
    wr(4'hB, 32'h0000_06E0, 9);
    wr(4'hC, 32'h7FFF_0000, 4);
    wr(4'hC, 32'h8000_FFF0, 4);
    wr(4'hE, 32'h1FE0_FFF0, 4);
    cleaner_locked = 1'b1;
    seen = 1'b0;
    for (int i = 0; i < 20 && !seen; i++) begin
      @(negedge mclk);
      if (tune_start === 1'b1) seen = 1'b1;
    end
    `CHK(seen, 1'b1)
    if (!seen) print_verdict();
    repeat (2) @(negedge mclk);
    `CHK(tune_waiting, 1'b0)
    cleaner_locked = 1'b0;
    wr(4'hF, 32'h0FFF_FFF0, 4);
    `CHK(tune_waiting, 1'b1)
    wr(4'hA, 32'h0000_0000, 4);
    `CHK(tune_waiting, 1'b0)
    host.send(4'h7, 32'h0002_0000, 4);
    repeat (12) @(negedge mclk);
    load_def();
    check_all();
    wr(4'h2, 32'h0000_0000, 4);
    srst = 1'b1;
    repeat (4) @(negedge mclk);
    srst = 1'b0;
    repeat (4) @(negedge mclk);
    load_def();
    check_all();
    print_verdict();
  end
endmodule

/* ccr_shift.sv */
`timescale 1ns/1ns
module ccr_shift import ccr_pkg::*; (
  input wire logic mclk,
  input wire logic srst,
  input wire logic sclk_level,
  input wire logic sdata_level,
  input wire logic latch_level,
  output logic wr_stb,
  output logic [CCR_WORD_W-1:0] wr_word
);
  // ==========================================
  // msb first; low nibble of the word is the address
  logic sclk_q;
  logic latch_q;
  logic [CCR_WORD_W-1:0] sr;
  wire sclk_rise = sclk_level & ~sclk_q;
  wire latch_rise = latch_level & ~latch_q;

  always_ff @(posedge mclk) begin
    if (srst) begin
      sclk_q <= 1'b0;
      latch_q <= 1'b0;
      sr <= '0;
      wr_stb <= 1'b0;
      wr_word <= '0;
    end else begin
      sclk_q <= sclk_level;
      latch_q <= latch_level;
      wr_stb <= latch_rise;
      if (sclk_rise) sr <= {sr[CCR_WORD_W-2:0], sdata_level};
      if (latch_rise) wr_word <= sr;
    end
  end
endmodule

/* ccr_sync.sv */
`timescale 1ns/1ns
module ccr_sync import ccr_pkg::*; #(
  parameter int N = 4
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [N-1:0] pin,
  output logic [N-1:0] level
);
  // ==========================================
  // three stages; a change counts once stages two and three agree
  logic [N-1:0] s1;
  logic [N-1:0] s2;
  logic [N-1:0] s3;
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_bit
      always_ff @(posedge mclk) begin
        if (srst) begin
          s1[i] <= 1'b0;
          s2[i] <= 1'b0;
          s3[i] <= 1'b0;
          level[i] <= 1'b0;
        end else begin
          s1[i] <= pin[i];
          s2[i] <= s1[i];
          s3[i] <= s2[i];
          if (s2[i] == s3[i]) level[i] <= s3[i];
        end
      end
    end
  endgenerate
endmodule
